// [pti_regs.svh]
`ifndef PTI_REGS_SVH
`define PTI_REGS_SVH

// Byte addresses on the register bus, one aligned 32-bit word each
`define PTI_ADDR_W 6
`define PTI_OFS_CTRL 6'h00
`define PTI_OFS_PHASE_LO 6'h04
`define PTI_OFS_PHASE_HI 6'h08
`define PTI_OFS_DUTY_LO 6'h0c
`define PTI_OFS_DUTY_HI 6'h10
`define PTI_OFS_PERIOD_LO 6'h14
`define PTI_OFS_PERIOD_HI 6'h18
`define PTI_OFS_COUNT_LO 6'h1c
`define PTI_OFS_COUNT_HI 6'h20
`define PTI_OFS_PERIPH_EN 6'h24
`define PTI_OFS_PERIPH_FLAG 6'h28
`define PTI_OFS_STATUS 6'h2c
`define PTI_OFS_CLEAR 6'h30
`define PTI_OFS_IRQ_EN 6'h34

// Field positions in the time base interrupt control register
`define PTI_EN_LSB 4
`define PTI_EN_MSB 7
`define PTI_FLAG_LSB 0
`define PTI_FLAG_MSB 3

// Reset values
`define PTI_CTRL_RST 8'h00
`define PTI_VALUE_RST 16'h0000
`define PTI_NIB_RST 4'h0
`define PTI_PIE_RST 8'h00

// Writable bits of the peripheral enable register, and this instance's slot
`define PTI_PIE_MASK 8'h77
`define PTI_PIR_INST_BIT 4

// Counter limits
`define PTI_COUNT_MAX 16'hffff
`define PTI_COUNT_ONE 16'h0001

`endif

// [pti_pkg.sv]
package pti_pkg;

   // One Avalon-MM request as driven by the bus master
   typedef struct packed {
      logic read;
      logic write;
      logic [5:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } pti_avm_req_t;

   // Time base events, packed in the same order as the flag bits 3..0
   typedef struct packed {
      logic overflow;
      logic phase;
      logic duty;
      logic period;
   } pti_evt_t;

endpackage

// [pti_time_base_irq.sv]
// Function
// - Flag overflow when counter wraps to zero
// - Flag phase when counter equals phase
// - Flag duty when counter equals duty
// - Flag period when counter equals period
// - Bit 7 enables overflow interrupts
// - Bit 6 enables phase interrupts
// - Bit 5 enables duty interrupts
// - Bit 4 enables period interrupts
// - Flags in bits 3..0, all bits read/write
// - Every control bit resets to zero
`timescale 1ns/1ns
`default_nettype none
`include "pti_regs.svh"

module pti_time_base_irq
   import pti_pkg::*;
(
   input wire logic sys_clk, // 100 MHz system clock
   input wire logic reset, // Asynchronous reset, active high
   input wire pti_avm_req_t bus_req, // Avalon-MM request from master
   output logic [31:0] readdata, // Avalon-MM read data
   output logic waitrequest, // Avalon-MM wait request
   input wire logic count_enable, // One-cycle tick advancing the counter
   output logic [15:0] time_base_counter, // Current counter value
   output pti_evt_t event_pulse, // Registered one-cycle event strobes
   output logic instance_time_base_request, // Per-instance request level
   output logic irq // Level interrupt from status and enable
);

   logic ack_r;
   logic [31:0] rdata_r;
   logic [31:0] rd_nxt;
   logic req;
   logic wr_stb;
   logic [7:0] wd;

   logic [15:0] counter_r;
   logic [15:0] count_inc;
   logic [15:0] phase_r;
   logic [15:0] duty_r;
   logic [15:0] period_r;
   logic [3:0] ien_r;
   logic [3:0] flag_r;
   logic [3:0] status_r;
   logic [3:0] sten_r;
   logic [7:0] pie_r;
   pti_evt_t evt_pulse_r;

   logic wr_ctrl;
   logic wr_ph_lo;
   logic wr_ph_hi;
   logic wr_dc_lo;
   logic wr_dc_hi;
   logic wr_pr_lo;
   logic wr_pr_hi;
   logic wr_cnt_lo;
   logic wr_cnt_hi;
   logic wr_cnt;
   logic wr_pie;
   logic wr_clr;
   logic wr_sten;

   logic tick;
   pti_evt_t evt;
   logic [3:0] evt_v;
   logic [7:0] ctrl_view;
   logic [7:0] pir_view;

   // Bus slave: every access waits exactly one cycle
   assign req = bus_req.read | bus_req.write;
   assign waitrequest = req & ~ack_r;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req & ~ack_r;
      end
   end

   // Writes land on the edge where waitrequest is low
   assign wr_stb = bus_req.write & ack_r & bus_req.byteenable[0];
   assign wd = bus_req.writedata[7:0];

   assign wr_ctrl = wr_stb & (bus_req.address == `PTI_OFS_CTRL);
   assign wr_ph_lo = wr_stb & (bus_req.address == `PTI_OFS_PHASE_LO);
   assign wr_ph_hi = wr_stb & (bus_req.address == `PTI_OFS_PHASE_HI);
   assign wr_dc_lo = wr_stb & (bus_req.address == `PTI_OFS_DUTY_LO);
   assign wr_dc_hi = wr_stb & (bus_req.address == `PTI_OFS_DUTY_HI);
   assign wr_pr_lo = wr_stb & (bus_req.address == `PTI_OFS_PERIOD_LO);
   assign wr_pr_hi = wr_stb & (bus_req.address == `PTI_OFS_PERIOD_HI);
   assign wr_cnt_lo = wr_stb & (bus_req.address == `PTI_OFS_COUNT_LO);
   assign wr_cnt_hi = wr_stb & (bus_req.address == `PTI_OFS_COUNT_HI);
   assign wr_pie = wr_stb & (bus_req.address == `PTI_OFS_PERIPH_EN);
   assign wr_clr = wr_stb & (bus_req.address == `PTI_OFS_CLEAR);
   assign wr_sten = wr_stb & (bus_req.address == `PTI_OFS_IRQ_EN);
   assign wr_cnt = wr_cnt_lo | wr_cnt_hi;

   // Time base counter; a software write takes priority over the tick
   assign count_inc = counter_r + `PTI_COUNT_ONE;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         counter_r <= `PTI_VALUE_RST;
      end else if (wr_cnt) begin
         if (wr_cnt_lo) begin
            counter_r[7:0] <= wd;
         end
         if (wr_cnt_hi) begin
            counter_r[15:8] <= wd;
         end
      end else if (count_enable) begin
         counter_r <= count_inc;
      end
   end

   assign time_base_counter = counter_r;

   // Compare settings, written one byte at a time
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         phase_r <= `PTI_VALUE_RST;
      end else begin
         if (wr_ph_lo) begin
            phase_r[7:0] <= wd;
         end
         if (wr_ph_hi) begin
            phase_r[15:8] <= wd;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         duty_r <= `PTI_VALUE_RST;
      end else begin
         if (wr_dc_lo) begin
            duty_r[7:0] <= wd;
         end
         if (wr_dc_hi) begin
            duty_r[15:8] <= wd;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         period_r <= `PTI_VALUE_RST;
      end else begin
         if (wr_pr_lo) begin
            period_r[7:0] <= wd;
         end
         if (wr_pr_hi) begin
            period_r[15:8] <= wd;
         end
      end
   end

   // Events fire only on a counting step, so a stalled counter sitting on
   // a match value does not re-set a flag that software has just cleared
   assign tick = count_enable & ~wr_cnt;

   assign evt.overflow = tick & (counter_r == `PTI_COUNT_MAX);
   assign evt.phase = tick & (count_inc == phase_r);
   assign evt.duty = tick & (count_inc == duty_r);
   assign evt.period = tick & (count_inc == period_r);
   assign evt_v = evt;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         evt_pulse_r <= '0;
      end else begin
         evt_pulse_r <= evt;
      end
   end

   assign event_pulse = evt_pulse_r;

   // Enable half of the control register
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         ien_r <= `PTI_NIB_RST;
      end else if (wr_ctrl) begin
         ien_r <= wd[`PTI_EN_MSB:`PTI_EN_LSB];
      end
   end

   // Flag and status bits, one per event; an event in the clearing
   // cycle wins so it is never lost
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_evt
         always_ff @(posedge sys_clk or posedge reset) begin
            if (reset) begin
               flag_r[gi] <= 1'b0;
            end else if (evt_v[gi]) begin
               flag_r[gi] <= 1'b1;
            end else if (wr_ctrl) begin
               flag_r[gi] <= wd[`PTI_FLAG_LSB + gi];
            end
         end

         always_ff @(posedge sys_clk or posedge reset) begin
            if (reset) begin
               status_r[gi] <= 1'b0;
            end else if (evt_v[gi]) begin
               status_r[gi] <= 1'b1;
            end else if (wr_clr && wd[gi]) begin
               status_r[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // Bits 7..4 gate overflow, phase, duty and period in that order
   assign instance_time_base_request = |(flag_r & ien_r);

   assign ctrl_view = {ien_r, flag_r};

   // Peripheral enable register keeps only its implemented bits
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pie_r <= `PTI_PIE_RST;
      end else if (wr_pie) begin
         pie_r <= wd & `PTI_PIE_MASK;
      end
   end

   // The flag register mirrors the request; it is cleared at its source
   always_comb begin
      pir_view = 8'h00;
      pir_view[`PTI_PIR_INST_BIT] = instance_time_base_request;
   end

   // Interrupt enable, same layout as status
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         sten_r <= `PTI_NIB_RST;
      end else if (wr_sten) begin
         sten_r <= wd[3:0];
      end
   end

   assign irq = |(status_r & sten_r);

   // Read mux; unmapped and write-only words read as zero
   always_comb begin
      rd_nxt = 32'h0000_0000;
      case (bus_req.address)
         `PTI_OFS_CTRL: begin
            rd_nxt[7:0] = ctrl_view;
         end
         `PTI_OFS_PHASE_LO: begin
            rd_nxt[7:0] = phase_r[7:0];
         end
         `PTI_OFS_PHASE_HI: begin
            rd_nxt[7:0] = phase_r[15:8];
         end
         `PTI_OFS_DUTY_LO: begin
            rd_nxt[7:0] = duty_r[7:0];
         end
         `PTI_OFS_DUTY_HI: begin
            rd_nxt[7:0] = duty_r[15:8];
         end
         `PTI_OFS_PERIOD_LO: begin
            rd_nxt[7:0] = period_r[7:0];
         end
         `PTI_OFS_PERIOD_HI: begin
            rd_nxt[7:0] = period_r[15:8];
         end
         `PTI_OFS_COUNT_LO: begin
            rd_nxt[7:0] = counter_r[7:0];
         end
         `PTI_OFS_COUNT_HI: begin
            rd_nxt[7:0] = counter_r[15:8];
         end
         `PTI_OFS_PERIPH_EN: begin
            rd_nxt[7:0] = pie_r;
         end
         `PTI_OFS_PERIPH_FLAG: begin
            rd_nxt[7:0] = pir_view;
         end
         `PTI_OFS_STATUS: begin
            rd_nxt[3:0] = status_r;
         end
         `PTI_OFS_IRQ_EN: begin
            rd_nxt[3:0] = sten_r;
         end
         default: begin
            rd_nxt = 32'h0000_0000;
         end
      endcase
   end

   // Sampled in the wait cycle and held through the accepting edge; a
   // 16-bit value read as two bytes can tear while the counter runs
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         rdata_r <= 32'h0000_0000;
      end else if (bus_req.read & ~ack_r) begin
         rdata_r <= rd_nxt;
      end
   end

   assign readdata = rdata_r;

endmodule

`default_nettype wire

// [pti_time_base_irq_assertions.sv]
`timescale 1ns/1ns
`default_nettype none
module pti_irq_chk
   import pti_pkg::*;
(
   input wire logic sys_clk, // Clock
   input wire logic reset, // Reset
   input wire pti_avm_req_t bus_req, // Bus request
   input wire logic [31:0] readdata, // Read data
   input wire logic waitrequest, // Wait
   input wire logic count_enable, // Tick
   input wire logic [15:0] time_base_counter, // Counter
   input wire pti_evt_t event_pulse, // Events
   input wire logic instance_time_base_request, // Request
   input wire logic irq // Interrupt
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   logic req, acc, cwr;
   assign req = bus_req.read | bus_req.write;
   assign acc = bus_req.write & ~waitrequest;
   // A counter write wins over a tick in the same cycle
   assign cwr = acc & bus_req.byteenable[0] & (bus_req.address == 6'h1c | bus_req.address == 6'h20);
   sequence s_tick;
      count_enable && !cwr;
   endsequence
   sequence s_wrap;
      time_base_counter == 16'h0000 && event_pulse.overflow;
   endsequence
   a_wait_once: assert property ($rose(req) |-> waitrequest ##1 !waitrequest)
      else $error("wait cycle wrong");
   a_count_step: assert property (s_tick |=> time_base_counter == $past(time_base_counter) + 16'h0001)
      else $error("counter did not step");
   a_wrap_flag: assert property (s_tick ##0 time_base_counter == 16'hffff |=> s_wrap)
      else $error("wrap not flagged");
   a_ovf_cause: assert property (event_pulse.overflow |-> $past(count_enable) && time_base_counter == 16'h0000)
      else $error("overflow without wrap");
   a_match_cause: assert property ((event_pulse & 4'h7) != 4'h0 |-> $past(count_enable))
      else $error("match without tick");
   a_req_rise: assert property ($rose(instance_time_base_request) |-> event_pulse != 4'h0 || $past(acc))
      else $error("request rose without cause");
   a_req_fall: assert property ($fell(instance_time_base_request) |-> $past(acc))
      else $error("request fell without write");
   a_irq_rise: assert property ($rose(irq) |-> event_pulse != 4'h0 || $past(acc))
      else $error("irq rose without cause");
   a_rdata_hold: assert property (!$past(bus_req.read) |-> $stable(readdata))
      else $error("read data moved");
   a_rdata_high: assert property (readdata[31:8] == 24'h000000)
      else $error("upper read data set");
endmodule
bind pti_time_base_irq pti_irq_chk chk (.sys_clk(sys_clk), .reset(reset), .bus_req(bus_req),
   .readdata(readdata), .waitrequest(waitrequest), .count_enable(count_enable),
   .time_base_counter(time_base_counter), .event_pulse(event_pulse),
   .instance_time_base_request(instance_time_base_request), .irq(irq));
`default_nettype wire

// [pti_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import pti_pkg::*;
   logic sys_clk = 0, reset = 1, count_enable = 0;
   pti_avm_req_t bus_req = '0;
   logic [31:0] readdata, rd;
   logic waitrequest, instance_time_base_request, irq;
   logic [15:0] time_base_counter;
   pti_evt_t event_pulse;
   // Model: phase, duty, period, counter
   logic [15:0] m_v [4];
   logic [7:0] m_ctl, m_pie;
   logic [3:0] m_st, m_ie;
   int bad_count = 0, tests_run = 0;
   logic [15:0] dir [8] = '{16'h00f0, 16'h1cfe, 16'h20ff, 16'h14ff, 16'h18ff, 16'h3404, 16'h3004, 16'h000f};
   pti_time_base_irq uut (.sys_clk(sys_clk), .reset(reset), .bus_req(bus_req), .readdata(readdata),
      .waitrequest(waitrequest), .count_enable(count_enable), .time_base_counter(time_base_counter),
      .event_pulse(event_pulse), .instance_time_base_request(instance_time_base_request), .irq(irq));
   initial forever #5 sys_clk = ~sys_clk;
   task automatic wrap_up();
      if (bad_count == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(string n, logic [31:0] e, logic [31:0] s);
      tests_run++;
      if (s !== e) begin
         $display("wrong value %s expected %h seen %h", n, e, s);
         bad_count++;
      end
   endtask
   task automatic bus(logic w, logic [5:0] a, logic [31:0] d, logic [3:0] be);
      int i;
      bus_req <= '{read: !w, write: w, address: a, writedata: d, byteenable: be};
      // Read just after the edge, these are the values that edge sampled
      for (i = 0; i < 50; i++) begin
         @(posedge sys_clk);
         if (waitrequest === 1'b0) break;
      end
      rd = readdata;
      bus_req <= '0;
      // One idle cycle keeps two requests apart
      @(posedge sys_clk);
      if (i == 50) begin
         bad_count++;
         wrap_up();
      end
   endtask
   function automatic logic req_m();
      return |(m_ctl[7:4] & m_ctl[3:0]);
   endfunction
   function automatic logic [7:0] mrd(logic [5:0] a);
      int k;
      k = (a - 4) / 4;
      if (a >= 6'h04 && a <= 6'h20) return 8'(m_v[k / 2] >> (8 * (k % 2)));
      case (a)
         6'h00: return m_ctl;
         6'h24: return m_pie;
         6'h28: return {3'h0, req_m(), 4'h0};
         6'h2c: return {4'h0, m_st};
         6'h34: return {4'h0, m_ie};
         default: return 8'h00;
      endcase
   endfunction
   function automatic void mwr(logic [5:0] a, logic [7:0] d);
      int k;
      k = (a - 4) / 4;
      if (a >= 6'h04 && a <= 6'h20) begin
         if (k % 2) m_v[k / 2][15:8] = d;
         else m_v[k / 2][7:0] = d;
      end
      case (a)
         6'h00: m_ctl = d;
         6'h24: m_pie = d & 8'h77;
         6'h30: m_st = m_st & ~d[3:0];
         6'h34: m_ie = d[3:0];
         default: ;
      endcase
   endfunction
   function automatic pti_evt_t mstep();
      pti_evt_t e;
      m_v[3] = m_v[3] + 16'h0001;
      e = {m_v[3] == 16'h0000, m_v[3] == m_v[0], m_v[3] == m_v[1], m_v[3] == m_v[2]};
      m_ctl[3:0] = m_ctl[3:0] | e;
      m_st = m_st | e;
      return e;
   endfunction
   function automatic void mreset();
      m_v = '{default: 16'h0000};
      m_ctl = 8'h00;
      m_pie = 8'h00;
      m_st = 4'h0;
      m_ie = 4'h0;
   endfunction
   task automatic wr(logic [5:0] a, logic [7:0] d);
      bus(1'b1, a, {24'h0, d}, 4'hf);
      mwr(a, d);
   endtask
   task automatic step(int n);
      pti_evt_t e;
      e = '0;
      repeat (n) begin
         count_enable <= 1'b1;
         @(posedge sys_clk);
         // Pre-edge values: pulse and count left by the previous step
         chk("event", e, event_pulse);
         chk("counter", m_v[3], time_base_counter);
         e = mstep();
      end
      count_enable <= 1'b0;
      @(posedge sys_clk);
      chk("event", e, event_pulse);
      chk("counter", m_v[3], time_base_counter);
   endtask
   task automatic check_all();
      int a;
      for (a = 0; a < 64; a += 4) begin
         bus(1'b0, a[5:0], 32'h0, 4'hf);
         chk("register", mrd(a[5:0]), rd);
      end
      @(negedge sys_clk);
      chk("request", req_m(), instance_time_base_request);
      chk("irq", |(m_st & m_ie), irq);
      @(posedge sys_clk);
   endtask
   initial begin
      int i, a;
      logic [7:0] d;
      void'($urandom(78));
      mreset();
      repeat (20) @(posedge sys_clk);
      reset <= 1'b0;
      check_all();
      for (i = 0; i < 8; i++) begin
         wr(dir[i][13:8], dir[i][7:0]);
         if (i == 4) step(3);
         if (i >= 4) check_all();
      end
      // Tick in the wait cycle counts; the tick under the counter write is lost
      count_enable <= 1'b1;
      bus(1'b1, 6'h1c, 32'h0000_0010, 4'hf);
      count_enable <= 1'b0;
      void'(mstep());
      mwr(6'h1c, 8'h10);
      void'(mstep());
      check_all();
      for (i = 0; i < 60; i++) begin
         a = 4 * ($urandom % 16);
         // Bias toward the top of the count so wraps and matches happen
         d = ($urandom % 2) ? 8'($urandom) : 8'hff - 8'($urandom % 4);
         if ($urandom % 8) wr(a[5:0], d);
         else bus(1'b1, a[5:0], {24'h0, d}, 4'he);
         step($urandom % 5);
         if (i % 10 == 9) check_all();
      end
      reset <= 1'b1;
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      mreset();
      check_all();
      wrap_up();
   end
endmodule
`default_nettype wire
